// >>> hdl/rsf_rail_sequencer.sv
module rsf_rail_sequencer
  import rsf_pkg::*;
#(
  parameter int STEP_CYCLES = DLY_STEP_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // serial control bus
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe_n,
  // interrupt line, open drain
  output logic irqLineOut,
  output logic irqLineOe_n,
  // monitors
  input wire rsf_faults_t faultIn,
  input wire rsf_events_t events,
  input wire logic [7:0] tempReading,
  input wire logic [7:0] thermHighLimit,
  input wire logic [7:0] thermLowLimit,
  // power-up sequencer
  input wire logic invertConvPowerGood,
  output logic [3:0] seqStep,
  output logic [3:0] railEnable
);
  localparam int CYC_W = $clog2(STEP_CYCLES + 1);
  generate
    if (STEP_CYCLES < 1) begin : g_bad_step
      $error("STEP_CYCLES must be at least 1");
    end
  endgenerate

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] sclSync, sdaSync, pgSync;
  logic sclD, sdaD;
  rsf_faults_t faultMeta, faultSync;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sclSync <= 2'h3;
      sdaSync <= 2'h3;
      pgSync <= 2'h0;
      sclD <= 1'b1;
      sdaD <= 1'b1;
      faultMeta <= '0;
      faultSync <= '0;
    end else begin
      sclSync <= {sclSync[0], sclIn};
      sdaSync <= {sdaSync[0], sdaIn};
      pgSync <= {pgSync[0], invertConvPowerGood};
      sclD <= sclSync[1];
      sdaD <= sdaSync[1];
      faultMeta <= faultIn;
      faultSync <= faultMeta;
    end
  end
  wire sclHi = sclSync[1];
  wire sdaHi = sdaSync[1];
  wire pgHi = pgSync[1];
  wire busStart = sclHi & sclD & sdaD & ~sdaHi;
  wire busStop = sclHi & sclD & ~sdaD & sdaHi;
  wire sclRise = sclHi & ~sclD;
  wire sclFall = ~sclHi & sclD;

  // ----------------------------------------
  // serial bus slave
  // ----------------------------------------
  rsf_bus_t bState, after;
  logic [3:0] cnt;
  logic [7:0] sh, rdSh, ptr, rdData;
  logic mAck;
  wire rcvState = (bState == B_ADDR) | (bState == B_REG) | (bState == B_WR);
  wire byteDone = sclFall & (cnt == 4'h8);
  wire addrHit = sh[7:1] == DEV_ADDR;
  wire wrEn = (bState == B_WR) & byteDone;
  wire rdLoad = sclFall & (((bState == B_ACK) & (after == B_RD)) | ((bState == B_RACK) & mAck));
  wire clrA = rdLoad & (ptr == ADDR_FLAGS_A);
  wire clrB = rdLoad & (ptr == ADDR_FLAGS_B);
  always_ff @(posedge clk) begin
    if (sys_rst | busStop) begin
      bState <= B_IDLE;
      after <= B_IDLE;
      cnt <= 4'h0;
      sh <= 8'h00;
      rdSh <= 8'hFF;
      mAck <= 1'b0;
      ptr <= sys_rst ? 8'h00 : ptr;
    end else if (busStart) begin
      bState <= B_ADDR;
      cnt <= 4'h0;
    end else begin
      if (rcvState & sclRise) begin
        sh <= {sh[6:0], sdaHi};
        cnt <= cnt + 4'h1;
      end
      if (rdLoad) begin
        rdSh <= rdData;
        ptr <= ptr + 8'h01;
      end else if ((bState == B_RD) & sclFall) begin
        rdSh <= {rdSh[6:0], 1'b1};
      end
      case (bState)
        B_ADDR: if (byteDone) begin
          bState <= addrHit ? B_ACK : B_IDLE;
          after <= sh[0] ? B_RD : B_REG;
        end
        B_REG: if (byteDone) begin
          ptr <= sh;
          bState <= B_ACK;
          after <= B_WR;
        end
        B_WR: if (byteDone) begin
          ptr <= ptr + 8'h01;
          bState <= B_ACK;
        end
        B_ACK: if (sclFall) begin
          bState <= after;
          cnt <= 4'h0;
        end
        B_RD: if (sclFall) begin
          cnt <= cnt + 4'h1;
          if (cnt == 4'h7) begin
            bState <= B_RACK;
          end
        end
        B_RACK: if (sclRise) begin
          mAck <= ~sdaHi;
        end else if (sclFall) begin
          bState <= mAck ? B_RD : B_IDLE;
          cnt <= 4'h0;
        end
        default: bState <= bState;
      endcase
    end
  end
  assign sdaOut = 1'b0;
  assign sdaOe_n = ~((bState == B_ACK) | ((bState == B_RD) & ~rdSh[7]));

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] irqEnB, riseOrder, riseDelays, flagsA, flagsB;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqEnB <= RST_IRQ_EN_B;
      riseOrder <= RST_RISE_ORDER;
      riseDelays <= RST_RISE_DELAYS;
    end else if (wrEn) begin
      irqEnB <= (ptr == ADDR_IRQ_EN_B) ? sh : irqEnB;
      riseOrder <= (ptr == ADDR_RISE_ORDER) ? sh : riseOrder;
      riseDelays <= (ptr == ADDR_RISE_DELAYS) ? sh : riseDelays;
    end
  end
  // flags read only; writes to them are dropped
  assign rdData = (ptr == ADDR_IRQ_EN_B) ? irqEnB :
                  (ptr == ADDR_FLAGS_A) ? flagsA :
                  (ptr == ADDR_FLAGS_B) ? flagsB :
                  (ptr == ADDR_RISE_ORDER) ? riseOrder :
                  (ptr == ADDR_RISE_DELAYS) ? riseDelays : 8'h00;

  // ----------------------------------------
  // temperature and event flags
  // ----------------------------------------
  logic [7:0] tempLast;
  logic havePrev, deltaFlag, measFlag, progFlag, convFlag;
  wire [7:0] absDiff = (tempReading >= tempLast) ? tempReading - tempLast
                                                  : tempLast - tempReading;
  wire deltaSet = events.tempValid & havePrev & (absDiff >= TEMP_DELTA_DEG);
  // event flags clear on read, a new event in the same cycle wins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tempLast <= 8'h00;
      havePrev <= 1'b0;
      deltaFlag <= 1'b0;
      measFlag <= 1'b0;
      progFlag <= 1'b0;
      convFlag <= 1'b0;
    end else begin
      tempLast <= events.tempValid ? tempReading : tempLast;
      havePrev <= havePrev | events.tempValid;
      deltaFlag <= deltaSet | (deltaFlag & ~clrA);
      measFlag <= events.measDone | (measFlag & ~clrA);
      progFlag <= events.progDone | (progFlag & ~clrA);
      convFlag <= events.convDone | (convFlag & ~clrB);
    end
  end
  always_comb begin
    flagsA = RST_FLAGS;
    flagsA[BIT_DELTA] = deltaFlag;
    flagsA[BIT_SHUTDOWN] = faultSync.overtemp;
    flagsA[BIT_HOT] = faultSync.hotWarn;
    flagsA[BIT_THERM_HI] = havePrev & (tempLast >= thermHighLimit);
    flagsA[BIT_THERM_LO] = havePrev & (tempLast <= thermLowLimit);
    flagsA[BIT_IN_UV] = faultSync.inputUv;
    flagsA[BIT_MEAS] = measFlag;
    flagsA[BIT_PROG] = progFlag;
    flagsB = RST_FLAGS;
    flagsB[BIT_BOOST_UV] = faultSync.boostUv;
    flagsB[BIT_INV_UV] = faultSync.invConvUv;
    flagsB[BIT_POS_GATE_UV] = faultSync.posGateUv;
    flagsB[BIT_NEG_GATE_UV] = faultSync.negGateUv;
    flagsB[BIT_POS_SRC_UV] = faultSync.posSrcUv;
    flagsB[BIT_NEG_SRC_UV] = faultSync.negSrcUv;
    flagsB[BIT_BIAS_FAULT] = faultSync.biasFault;
    flagsB[BIT_CONV] = convFlag;
  end
  // irq pulled low only while enabled
  assign irqLineOut = 1'b0;
  assign irqLineOe_n = ~(convFlag & irqEnB[BIT_CONV_EN]);

  // ----------------------------------------
  // power-up sequencer
  // ----------------------------------------
  rsf_seq_t sqState;
  logic [1:0] seqIdx, unitCnt;
  logic [CYC_W-1:0] cyc;
  logic [3:0] railMatch;
  // delay is (code + 1) steps of 3 ms
  wire [1:0] curCode = riseDelays[{seqIdx, 1'b0} +: 2];
  wire tick = cyc == CYC_W'(STEP_CYCLES - 1);
  wire strobeNow = (sqState == SQ_WAIT) & tick & (unitCnt == curCode);
  // rail r order field at bits 2r+1:2r
  for (genvar r = 0; r < 4; r++) begin : g_rail
    assign railMatch[r] = riseOrder[2 * r +: 2] == seqIdx;
  end
  // timing starts once power good is seen high
  always_ff @(posedge clk) begin
    if (sys_rst | ~pgHi) begin
      sqState <= SQ_OFF;
      seqIdx <= 2'h0;
      unitCnt <= 2'h0;
      cyc <= '0;
    end else if (sqState == SQ_OFF) begin
      sqState <= SQ_WAIT;
    end else if (sqState == SQ_WAIT) begin
      cyc <= tick ? '0 : cyc + CYC_W'(1);
      unitCnt <= strobeNow ? 2'h0 : (tick ? unitCnt + 2'h1 : unitCnt);
      // next strobe uses the next delay field
      seqIdx <= strobeNow ? seqIdx + 2'h1 : seqIdx;
      sqState <= (strobeNow & (seqIdx == 2'h3)) ? SQ_UP : SQ_WAIT;
    end
  end
  // rails sharing a strobe rise together
  always_ff @(posedge clk) begin
    if (sys_rst | ~pgHi) begin
      seqStep <= 4'h0;
      railEnable <= 4'h0;
    end else begin
      seqStep <= strobeNow ? (4'h1 << seqIdx) : 4'h0;
      railEnable <= strobeNow ? (railEnable | railMatch) : railEnable;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  int gapCnt;
  always_ff @(posedge clk) begin
    if (sys_rst | (sqState == SQ_OFF)) begin
      gapCnt <= 0;
    end else begin
      gapCnt <= (seqStep != 4'h0) ? 1 : gapCnt + 1;
    end
  end
  a_irq_conv_low: assert property (
    events.convDone && irqEnB[BIT_CONV_EN] |=> !irqLineOe_n)
    else $error("irq not driven after conversion done");
  a_irq_masked: assert property (
    !irqEnB[BIT_CONV_EN] |-> irqLineOe_n)
    else $error("irq driven while disabled");
  a_delta_set: assert property (
    events.tempValid && havePrev && absDiff >= TEMP_DELTA_DEG |=> flagsA[BIT_DELTA])
    else $error("temperature change flag missed");
  a_shutdown_bit: assert property (
    faultIn.overtemp [*3] |-> flagsA[BIT_SHUTDOWN])
    else $error("shutdown bit not shown");
  a_hot_bit: assert property (
    !faultIn.hotWarn [*3] |-> !flagsA[BIT_HOT])
    else $error("warning bit stuck");
  a_meas_sticky: assert property (
    events.measDone |=> flagsA[BIT_MEAS] [*2] or (flagsA[BIT_MEAS] ##1 $past(clrA)))
    else $error("measure done flag lost");
  a_conv_set: assert property (
    events.convDone |=> flagsB[BIT_CONV])
    else $error("conversion done flag missed");
  a_reset_values: assert property (
    $past(sys_rst) |-> riseOrder == RST_RISE_ORDER && riseDelays == RST_RISE_DELAYS)
    else $error("sequence registers wrong after reset");
  a_strobe_gap: assert property (
    seqStep != 4'h0 |-> gapCnt == (int'($past(curCode)) + 1) * STEP_CYCLES)
    else $error("strobe spacing wrong");
  a_rail_enable: assert property (
    seqStep != 4'h0 |-> (railEnable & $past(railMatch)) == $past(railMatch))
    else $error("rail not enabled at its strobe");
  c_seq_done: cover property ($rose(sqState == SQ_UP));
  c_irq_low: cover property ($fell(irqLineOe_n));
  // the flags B load follows a flags A load within 1 to 1000 cycles
  c_flags_read: cover property (clrA ##[1:1000] clrB);
  c_order_write: cover property (wrEn && ptr == ADDR_RISE_ORDER);
endmodule

// >>> hdl/rsf_pkg.sv
package rsf_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_IRQ_EN_B = 8'h06;
  localparam logic [7:0] ADDR_FLAGS_A = 8'h07;
  localparam logic [7:0] ADDR_FLAGS_B = 8'h08;
  localparam logic [7:0] ADDR_RISE_ORDER = 8'h09;
  localparam logic [7:0] ADDR_RISE_DELAYS = 8'h0A;
  localparam logic [7:0] RST_IRQ_EN_B = 8'hFF;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_RISE_ORDER = 8'hE4;
  localparam logic [7:0] RST_RISE_DELAYS = 8'h55;
  // flags A bit positions
  localparam int BIT_DELTA = 7;
  localparam int BIT_SHUTDOWN = 6;
  localparam int BIT_HOT = 5;
  localparam int BIT_THERM_HI = 4;
  localparam int BIT_THERM_LO = 3;
  localparam int BIT_IN_UV = 2;
  localparam int BIT_MEAS = 1;
  localparam int BIT_PROG = 0;
  // flags B bit positions
  localparam int BIT_BOOST_UV = 7;
  localparam int BIT_POS_GATE_UV = 6;
  localparam int BIT_INV_UV = 5;
  localparam int BIT_POS_SRC_UV = 4;
  localparam int BIT_NEG_GATE_UV = 3;
  localparam int BIT_BIAS_FAULT = 2;
  localparam int BIT_NEG_SRC_UV = 1;
  localparam int BIT_CONV = 0;
  // enable bit for conversion done
  localparam int BIT_CONV_EN = 0;
  // ----------------------------------------
  // timing and thresholds
  // ----------------------------------------
  localparam logic [7:0] TEMP_DELTA_DEG = 8'h03;
  localparam int CLK_PERIOD_NS = 25;
  localparam int DLY_STEP_US = 3000;
  localparam int DLY_STEP_CYCLES = DLY_STEP_US * 1000 / CLK_PERIOD_NS;
  // bus address, value arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h48;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic overtemp;
    logic hotWarn;
    logic inputUv;
    logic boostUv;
    logic posGateUv;
    logic invConvUv;
    logic posSrcUv;
    logic negGateUv;
    logic biasFault;
    logic negSrcUv;
  } rsf_faults_t;
  typedef struct packed {
    logic tempValid;
    logic measDone;
    logic progDone;
    logic convDone;
  } rsf_events_t;
  typedef enum logic [2:0] {B_IDLE, B_ADDR, B_REG, B_WR, B_ACK, B_RD, B_RACK} rsf_bus_t;
  typedef enum logic [1:0] {SQ_OFF, SQ_WAIT, SQ_UP} rsf_seq_t;
endpackage

// >>> test/rsf_host_model.sv
module rsf_host_model
  import rsf_pkg::*;
(
  // bus pins
  input wire logic clk,
  input wire logic sdaWire,
  output logic scl,
  output logic sdaDrv
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end
  // six clocks a phase leaves margin over the pin synchronisers
  task automatic half();
    repeat (6) @(negedge clk);
  endtask
  task automatic put_bit(input logic b, output logic s);
    @(negedge clk);
    sdaDrv = b;
    half();
    scl = 1'b1;
    half();
    s = sdaWire;
    scl = 1'b0;
  endtask
  task automatic start();
    @(negedge clk);
    sdaDrv = 1'b1;
    half();
    scl = 1'b1;
    half();
    sdaDrv = 1'b0;
    half();
    scl = 1'b0;
  endtask
  task automatic stop();
    @(negedge clk);
    sdaDrv = 1'b0;
    half();
    scl = 1'b1;
    half();
    sdaDrv = 1'b1;
    half();
  endtask
  // one byte out and one in; last high releases the line for ack or nack
  task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                      output logic ack);
    for (int i = 7; i >= 0; i--) put_bit(tx[i], rx[i]);
    put_bit(last, ack);
  endtask
  // ----------------------------------------
  // register access
  // ----------------------------------------
  // flags are read only in the slave; a write to them is still sent
  task automatic access(input logic rd, input logic [7:0] off, input logic [7:0] wv,
                        output logic [7:0] rv, output logic [2:0] acks);
    logic [7:0] junk;
    start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, junk, acks[2]);
    xfer(off, 1'b1, junk, acks[1]);
    if (rd) begin
      start();
      xfer({DEV_ADDR, 1'b1}, 1'b1, junk, acks[0]);
      xfer(8'hFF, 1'b1, rv, junk[0]);
    end else begin
      xfer(wv, 1'b1, rv, acks[0]);
    end
    stop();
  endtask
endmodule

// >>> test/test_rsf_rail_sequencer.sv
module test_rsf_rail_sequencer
  import rsf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STEP = 4;
  logic clk, sysRst, scl, sdaDrv, sdaOut, sdaOe_n, irqOut, irqOe_n, pg, sdaWire, irqWire;
  rsf_faults_t faultIn;
  rsf_events_t events;
  logic [7:0] tempReading, hiLim, loLim, one;
  logic [3:0] seqStep, railEnable;
  int n_fail, n_tests, ta, tb;
  int posTab[10] = '{BIT_NEG_SRC_UV, BIT_BIAS_FAULT, BIT_NEG_GATE_UV, BIT_POS_SRC_UV,
                     BIT_INV_UV, BIT_POS_GATE_UV, BIT_BOOST_UV, BIT_IN_UV, BIT_HOT, BIT_SHUTDOWN};
  logic [7:0] tr[5] = '{8'h32, 8'h35, 8'h37, 8'h3C, 8'h28};
  logic [7:0] te[5] = '{8'h00, 8'h80, 8'h00, 8'h90, 8'h88};
  // pull-ups on both open-drain lines
  assign sdaWire = sdaDrv & (sdaOe_n | sdaOut);
  assign irqWire = irqOe_n | irqOut;
  rsf_rail_sequencer #(.STEP_CYCLES(STEP)) rsf_rail_sequencer_i (
    .clk(clk), .sys_rst(sysRst), .sclIn(scl), .sdaIn(sdaWire), .sdaOut(sdaOut),
    .sdaOe_n(sdaOe_n), .irqLineOut(irqOut), .irqLineOe_n(irqOe_n), .faultIn(faultIn),
    .events(events), .tempReading(tempReading), .thermHighLimit(hiLim),
    .thermLowLimit(loLim), .invertConvPowerGood(pg), .seqStep(seqStep),
    .railEnable(railEnable)
  );
  rsf_host_model rsf_host_model_i (
    .clk(clk), .sdaWire(sdaWire), .scl(scl), .sdaDrv(sdaDrv)
  );
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic rd_chk(input string w, input logic [7:0] off, input logic [7:0] exp);
    logic [7:0] v;
    logic [2:0] a;
    rsf_host_model_i.access(1'b1, off, 8'h00, v, a);
    check("ack", 16'(a), 16'h0000);
    check(w, 16'(v), 16'(exp));
  endtask
  task automatic wr(input logic [7:0] off, input logic [7:0] val);
    logic [7:0] v;
    logic [2:0] a;
    rsf_host_model_i.access(1'b0, off, val, v, a);
    check("ack", 16'(a), 16'h0000);
  endtask
  task automatic pulse(input logic [3:0] e);
    @(negedge clk);
    events = rsf_events_t'(e);
    @(negedge clk);
    events = '0;
    repeat (3) @(negedge clk);
  endtask
  task automatic seq_run(input logic [7:0] ord, input logic [7:0] dly, output int t1);
    int t[4];
    int k;
    int n;
    logic [3:0] expEn;
    wr(ADDR_RISE_ORDER, ord);
    wr(ADDR_RISE_DELAYS, dly);
    @(negedge clk);
    pg = 1'b1;
    k = 0;
    n = 0;
    while (k < 4 && n < 1000) begin
      @(negedge clk);
      n++;
      if (seqStep !== 4'h0) begin
        expEn = 4'h0;
        for (int r = 0; r < 4; r++) if (ord[2*r +: 2] <= k) expEn[r] = 1'b1;
        check("strobe", 16'(seqStep), 16'(4'h1 << k));
        check("rails", 16'(railEnable), 16'(expEn));
        t[k] = n;
        if (k > 0) begin
          check("gap", 16'(t[k] - t[k-1]), 16'((dly[2*k +: 2] + 1) * STEP));
        end
        k++;
      end
    end
    if (k < 4) begin
      n_fail++;
      close_out();
    end
    t1 = t[0];
    pg = 1'b0;
    repeat (4) @(negedge clk);
    check("rails off", 16'(railEnable), 16'h0000);
  endtask
  // ----------------------------------------
  // bounded run
  // ----------------------------------------
  initial begin
    repeat (95000) @(posedge clk);
    n_fail++;
    close_out();
  end
  initial begin
    sysRst = 1'b1;
    faultIn = '0;
    events = '0;
    tempReading = 8'h00;
    hiLim = 8'h3C;
    loLim = 8'h28;
    pg = 1'b0;
    repeat (5) @(negedge clk);
    sysRst = 1'b0;
    repeat (3) @(negedge clk);
    rd_chk("order", ADDR_RISE_ORDER, 8'hE4);
    rd_chk("delays", ADDR_RISE_DELAYS, 8'h55);
    rd_chk("flagsA", ADDR_FLAGS_A, 8'h00);
    rd_chk("unmapped", 8'h20, 8'h00);
    wr(ADDR_FLAGS_A, 8'hFF);
    rd_chk("flagsA ro", ADDR_FLAGS_A, 8'h00);
    for (int i = 0; i < 10; i++) begin
      faultIn = rsf_faults_t'(10'h001 << i);
      one = 8'h01 << posTab[i];
      repeat (4) @(negedge clk);
      rd_chk("flagsA fault", ADDR_FLAGS_A, (i > 6) ? one : 8'h00);
      rd_chk("flagsB fault", ADDR_FLAGS_B, (i > 6) ? 8'h00 : one);
    end
    faultIn = '0;
    pulse(4'b0100);
    rd_chk("measure done", ADDR_FLAGS_A, 8'h02);
    rd_chk("read clears", ADDR_FLAGS_A, 8'h00);
    pulse(4'b0010);
    rd_chk("program done", ADDR_FLAGS_A, 8'h01);
    pulse(4'b0001);
    check("irq low", 16'(irqWire), 16'h0000);
    rd_chk("conv done", ADDR_FLAGS_B, 8'h01);
    check("irq freed", 16'(irqWire), 16'h0001);
    wr(ADDR_IRQ_EN_B, 8'hFE);
    pulse(4'b0001);
    check("irq masked", 16'(irqWire), 16'h0001);
    rd_chk("conv masked", ADDR_FLAGS_B, 8'h01);
    for (int i = 0; i < 5; i++) begin
      tempReading = tr[i];
      pulse(4'b1000);
      rd_chk("temperature", ADDR_FLAGS_A, te[i]);
    end
    seq_run(8'h0D, 8'h6C, ta);
    seq_run(8'hE4, 8'h93, tb);
    check("first delay", 16'(tb - ta), 16'(3 * STEP));
    close_out();
  end
endmodule
